// ===== common/pfd_consts.vh
// Constants for the pin function and drive select block
`ifndef PFD_CONSTS_VH
`define PFD_CONSTS_VH

// Register byte offsets on the APB
`define PFD_OFF_DRV_CD 8'h00
`define PFD_OFF_DRV_EF 8'h04
`define PFD_OFF_PA_LOW 8'h08
`define PFD_OFF_PA_HIGH 8'h0c
`define PFD_OFF_PB_LOW 8'h10
`define PFD_OFF_PB_HIGH 8'h14
`define PFD_OFF_INSRC0 8'h18
`define PFD_OFF_INSRC1 8'h1c
`define PFD_OFF_PA_STAT 8'h20
`define PFD_OFF_PB_STAT 8'h24

// Reset values and masks
`define PFD_RST_REG 8'h00
`define PFD_INSRC1_MASK 8'h03
`define PFD_RD_ZERO 32'h0000_0000

// Two-bit field positions inside an 8-bit register
`define PFD_FLD3_MSB 7
`define PFD_FLD3_LSB 6
`define PFD_FLD2_MSB 5
`define PFD_FLD2_LSB 4
`define PFD_FLD1_MSB 3
`define PFD_FLD1_LSB 2
`define PFD_FLD0_MSB 1
`define PFD_FLD0_LSB 0

// Input source select bit positions
`define PFD_IS0_SCS_BIT 7
`define PFD_IS0_SDI_BIT 6
`define PFD_IS0_SCK_BIT 5
`define PFD_IS0_PERIODIC_TIMER_CAPTURE_IN_BIT 3
`define PFD_IS0_COMPACT_TIMER_CLK_IN_BIT 1
`define PFD_IS0_PERIODIC_TIMER_CLK_IN_BIT 0
`define PFD_IS1_EXT_INTERRUPT_ONE_BIT 1
`define PFD_IS1_EXT_INTERRUPT_ZERO_BIT 0

// Field code that hands a pin to its peripheral
`define PFD_CODE_PERIPH 2'b11

// Pins that own a peripheral function on code 11
`define PFD_PA_FUNC_MASK 8'hfa
`define PFD_PB_FUNC_MASK 8'hdf

`endif

// ===== logic/pfd_sync.v
// Two flip-flop synchroniser for pad inputs
`default_nettype none
module pfd_sync #(
  parameter WIDTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  // Stage one feeds only stage two to keep metastability contained
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== logic/pfd_pin_cell.v
// Output mux for one shared pad: GPIO latch or peripheral signal
`default_nettype none
`include "pfd_consts.vh"
module pfd_pin_cell (
  input wire pclk,
  input wire presetn,
  input wire [1:0] code,
  input wire has_func,
  input wire gpio_data,
  input wire gpio_dir,
  input wire periph_out,
  input wire periph_oe,
  output reg pad_out,
  output reg pad_oe
);
  wire periph_sel;

  assign periph_sel = has_func && (code == `PFD_CODE_PERIPH);

  // Direction bit high means input, so the pad is released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else if (periph_sel) begin
      pad_out <= periph_out;
      pad_oe <= periph_oe;
    end else begin
      pad_out <= gpio_data;
      pad_oe <= ~gpio_dir;
    end
  end
endmodule
`default_nettype wire

// ===== logic/pfd_pin_mux.v
// APB pin function, input source and drive level selection block
//
// Behaviour
// - Drive code 00..11 means level 0..3
// - Drive CD bits 7:6 PD6-4, 5:4 PD3-0
// - Drive CD bits 3:2 PC7-4, 1:0 PC3-0
// - Drive EF bits 7:6 PF7-4, 5:4 PF3-0
// - Drive EF bits 3:2 PE4, 1:0 PE3-0
// - Output function fields plus input source selects
// - PA3 code 11 gives serial data out
// - PA2 and PA0 always GPIO
// - PA1 code 11 gives serial chip select
// - PA7 UART transmit, PA6 UART receive
// - PA5 serial clock, PA4 serial data line
// - PB3 compact timer out, PB0 comparator out
// - PB2 periodic inverted out, PB1 periodic out
// - PB7 crystal two, PB6 crystal one, PB5 GPIO
// - PB4 compact timer inverted out
// - Chip select input from PA1 or PF0
// - Serial data input from PA4 or PF2
// - Serial clock input from PA5 or PF3
// - Interrupt one input from PA3 or PA7
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
`include "pfd_consts.vh"
module pfd_pin_mux #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] gpio_a_data,
  input wire [7:0] gpio_a_dir,
  input wire [7:0] gpio_b_data,
  input wire [7:0] gpio_b_dir,
  input wire [7:0] pad_a_in,
  input wire [7:0] pad_b_in,
  input wire [7:0] pad_c_in,
  input wire [4:0] pad_e_in,
  input wire [7:0] pad_f_in,
  output wire [7:0] pad_a_out,
  output wire [7:0] pad_a_oe,
  output wire [7:0] pad_b_out,
  output wire [7:0] pad_b_oe,
  input wire serial_data_out,
  input wire serial_chip_select_out,
  input wire serial_chip_select_oe,
  input wire serial_clock_out,
  input wire serial_clock_oe,
  input wire serial_data_line_out,
  input wire serial_data_line_oe,
  input wire uart_tx_out,
  input wire compact_timer_out,
  input wire compact_timer_out_inv,
  input wire periodic_timer_out,
  input wire periodic_timer_out_inv,
  input wire comparator_out,
  output reg crystal_pin_one,
  output reg crystal_pin_two,
  output reg ext_interrupt_zero,
  output reg ext_interrupt_one,
  output reg serial_chip_select,
  output reg serial_data_in,
  output reg serial_clock_in,
  output reg uart_rx_in,
  output reg periodic_timer_clk_in,
  output reg periodic_timer_capture_in,
  output reg compact_timer_clk_in,
  output reg [15:0] drive_c_lvl,
  output reg [13:0] drive_d_lvl,
  output reg [9:0] drive_e_lvl,
  output reg [15:0] drive_f_lvl
);
  reg [7:0] drive_level_sel_cd;
  reg [7:0] drive_level_sel_ef;
  reg [7:0] porta_func_sel_low;
  reg [7:0] porta_func_sel_high;
  reg [7:0] portb_func_sel_low;
  reg [7:0] portb_func_sel_high;
  reg [7:0] input_source_select_0;
  reg [7:0] input_source_select_1;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire [36:0] pad_sync;
  wire [7:0] sa;
  wire [7:0] sb;
  wire [7:0] sc;
  wire [4:0] se;
  wire [7:0] sf;
  wire [15:0] code_a;
  wire [15:0] code_b;
  wire [7:0] pa_pout;
  wire [7:0] pa_poe;
  wire [7:0] pb_pout;
  wire [7:0] pb_poe;
  wire [7:0] pa_mask;
  wire [7:0] pb_mask;
  wire wr_take;
  wire acc_start;
  wire [1:0] pb6_code;
  wire [1:0] pb7_code;

  // Pads come from outside the clock domain
  pfd_sync #(
    .WIDTH(37)
  ) u_pad_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pad_f_in, pad_e_in, pad_c_in, pad_b_in, pad_a_in}),
    .sync_out(pad_sync)
  );

  assign sa = pad_sync[7:0];
  assign sb = pad_sync[15:8];
  assign sc = pad_sync[23:16];
  assign se = pad_sync[28:24];
  assign sf = pad_sync[36:29];

  // APB: one wait state, so every access ends on its second penable cycle
  assign acc_start = psel && penable && !pready;
  assign wr_take = psel && penable && pready && pwrite && !pslverr;

  // Status words are read-only; a write there is refused, not ignored silently
  always @* begin
    next_prdata = `PFD_RD_ZERO;
    next_pslverr = 1'b0;
    if (paddr == `PFD_OFF_DRV_CD) begin
      next_prdata[7:0] = drive_level_sel_cd;
    end else if (paddr == `PFD_OFF_DRV_EF) begin
      next_prdata[7:0] = drive_level_sel_ef;
    end else if (paddr == `PFD_OFF_PA_LOW) begin
      next_prdata[7:0] = porta_func_sel_low;
    end else if (paddr == `PFD_OFF_PA_HIGH) begin
      next_prdata[7:0] = porta_func_sel_high;
    end else if (paddr == `PFD_OFF_PB_LOW) begin
      next_prdata[7:0] = portb_func_sel_low;
    end else if (paddr == `PFD_OFF_PB_HIGH) begin
      next_prdata[7:0] = portb_func_sel_high;
    end else if (paddr == `PFD_OFF_INSRC0) begin
      next_prdata[7:0] = input_source_select_0;
    end else if (paddr == `PFD_OFF_INSRC1) begin
      next_prdata[7:0] = input_source_select_1 & `PFD_INSRC1_MASK;
    end else if (paddr == `PFD_OFF_PA_STAT) begin
      next_prdata[7:0] = sa;
      next_pslverr = pwrite;
    end else if (paddr == `PFD_OFF_PB_STAT) begin
      next_prdata[7:0] = sb;
      next_pslverr = pwrite;
    end else begin
      next_pslverr = 1'b1;
    end
    if (pwrite) begin
      next_prdata = `PFD_RD_ZERO;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PFD_RD_ZERO;
    end else if (acc_start) begin
      pready <= 1'b1;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PFD_RD_ZERO;
    end
  end

  // Writes land only at the edge where pready is sampled high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_level_sel_cd <= `PFD_RST_REG;
      drive_level_sel_ef <= `PFD_RST_REG;
      porta_func_sel_low <= `PFD_RST_REG;
      porta_func_sel_high <= `PFD_RST_REG;
      portb_func_sel_low <= `PFD_RST_REG;
      portb_func_sel_high <= `PFD_RST_REG;
      input_source_select_0 <= `PFD_RST_REG;
      input_source_select_1 <= `PFD_RST_REG;
    end else if (wr_take) begin
      if (paddr == `PFD_OFF_DRV_CD) begin
        drive_level_sel_cd <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_DRV_EF) begin
        drive_level_sel_ef <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_PA_LOW) begin
        porta_func_sel_low <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_PA_HIGH) begin
        porta_func_sel_high <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_PB_LOW) begin
        portb_func_sel_low <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_PB_HIGH) begin
        portb_func_sel_high <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_INSRC0) begin
        input_source_select_0 <= pwdata[7:0];
      end else if (paddr == `PFD_OFF_INSRC1) begin
        input_source_select_1 <= pwdata[7:0] & `PFD_INSRC1_MASK;
      end
    end
  end

  // Drive levels pass the code unchanged; the pad cell decodes the current
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_c_lvl <= {8{2'b00}};
      drive_d_lvl <= {7{2'b00}};
      drive_e_lvl <= {5{2'b00}};
      drive_f_lvl <= {8{2'b00}};
    end else begin
      drive_d_lvl <= {{3{drive_level_sel_cd[`PFD_FLD3_MSB:`PFD_FLD3_LSB]}},
                      {4{drive_level_sel_cd[`PFD_FLD2_MSB:`PFD_FLD2_LSB]}}};
      drive_c_lvl <= {{4{drive_level_sel_cd[`PFD_FLD1_MSB:`PFD_FLD1_LSB]}},
                      {4{drive_level_sel_cd[`PFD_FLD0_MSB:`PFD_FLD0_LSB]}}};
      drive_f_lvl <= {{4{drive_level_sel_ef[`PFD_FLD3_MSB:`PFD_FLD3_LSB]}},
                      {4{drive_level_sel_ef[`PFD_FLD2_MSB:`PFD_FLD2_LSB]}}};
      drive_e_lvl <= {drive_level_sel_ef[`PFD_FLD1_MSB:`PFD_FLD1_LSB],
                      {4{drive_level_sel_ef[`PFD_FLD0_MSB:`PFD_FLD0_LSB]}}};
    end
  end

  // Pin i uses bits 2i+1:2i of the high:low register pair
  assign code_a = {porta_func_sel_high, porta_func_sel_low};
  assign code_b = {portb_func_sel_high, portb_func_sel_low};
  assign pa_mask = `PFD_PA_FUNC_MASK;
  assign pb_mask = `PFD_PB_FUNC_MASK;

  // Port A peripheral outputs per pin; PA6 receive leaves the pad released
  assign pa_pout[0] = 1'b0;
  assign pa_poe[0] = 1'b0;
  assign pa_pout[1] = serial_chip_select_out;
  assign pa_poe[1] = serial_chip_select_oe;
  assign pa_pout[2] = 1'b0;
  assign pa_poe[2] = 1'b0;
  assign pa_pout[3] = serial_data_out;
  assign pa_poe[3] = 1'b1;
  assign pa_pout[4] = serial_data_line_out;
  assign pa_poe[4] = serial_data_line_oe;
  assign pa_pout[5] = serial_clock_out;
  assign pa_poe[5] = serial_clock_oe;
  assign pa_pout[6] = 1'b0;
  assign pa_poe[6] = 1'b0;
  assign pa_pout[7] = uart_tx_out;
  assign pa_poe[7] = 1'b1;

  // Port B; crystal pins are analog so the digital driver stays off
  assign pb_pout[0] = comparator_out;
  assign pb_poe[0] = 1'b1;
  assign pb_pout[1] = periodic_timer_out;
  assign pb_poe[1] = 1'b1;
  assign pb_pout[2] = periodic_timer_out_inv;
  assign pb_poe[2] = 1'b1;
  assign pb_pout[3] = compact_timer_out;
  assign pb_poe[3] = 1'b1;
  assign pb_pout[4] = compact_timer_out_inv;
  assign pb_poe[4] = 1'b1;
  assign pb_pout[5] = 1'b0;
  assign pb_poe[5] = 1'b0;
  assign pb_pout[6] = 1'b0;
  assign pb_poe[6] = 1'b0;
  assign pb_pout[7] = 1'b0;
  assign pb_poe[7] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pfd_pin_cell u_cell_a (
        .pclk(pclk),
        .presetn(presetn),
        .code(code_a[2*gi+1:2*gi]),
        .has_func(pa_mask[gi]),
        .gpio_data(gpio_a_data[gi]),
        .gpio_dir(gpio_a_dir[gi]),
        .periph_out(pa_pout[gi]),
        .periph_oe(pa_poe[gi]),
        .pad_out(pad_a_out[gi]),
        .pad_oe(pad_a_oe[gi])
      );
      pfd_pin_cell u_cell_b (
        .pclk(pclk),
        .presetn(presetn),
        .code(code_b[2*gi+1:2*gi]),
        .has_func(pb_mask[gi]),
        .gpio_data(gpio_b_data[gi]),
        .gpio_dir(gpio_b_dir[gi]),
        .periph_out(pb_pout[gi]),
        .periph_oe(pb_poe[gi]),
        .pad_out(pad_b_out[gi]),
        .pad_oe(pad_b_oe[gi])
      );
    end
  endgenerate

  // Crystal connect is an analog switch enable, so only the field code matters
  assign pb6_code = portb_func_sel_high[`PFD_FLD2_MSB:`PFD_FLD2_LSB];
  assign pb7_code = portb_func_sel_high[`PFD_FLD3_MSB:`PFD_FLD3_LSB];

  // Input routing; sources follow the select bits even if the output field
  // is wrong, so software must keep both in step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_pin_one <= 1'b0;
      crystal_pin_two <= 1'b0;
      ext_interrupt_zero <= 1'b0;
      ext_interrupt_one <= 1'b0;
      serial_chip_select <= 1'b0;
      serial_data_in <= 1'b0;
      serial_clock_in <= 1'b0;
      uart_rx_in <= 1'b0;
      periodic_timer_clk_in <= 1'b0;
      periodic_timer_capture_in <= 1'b0;
      compact_timer_clk_in <= 1'b0;
    end else begin
      crystal_pin_one <= (pb6_code == `PFD_CODE_PERIPH);
      crystal_pin_two <= (pb7_code == `PFD_CODE_PERIPH);
      serial_chip_select <= input_source_select_0[`PFD_IS0_SCS_BIT] ? sf[0] : sa[1];
      serial_data_in <= input_source_select_0[`PFD_IS0_SDI_BIT] ? sf[2] : sa[4];
      serial_clock_in <= input_source_select_0[`PFD_IS0_SCK_BIT] ? sf[3] : sa[5];
      ext_interrupt_one <= input_source_select_1[`PFD_IS1_EXT_INTERRUPT_ONE_BIT] ? sa[7] : sa[3];
      ext_interrupt_zero <= input_source_select_1[`PFD_IS1_EXT_INTERRUPT_ZERO_BIT] ? sa[6] : sa[1];
      uart_rx_in <= sa[6];
      periodic_timer_clk_in <= input_source_select_0[`PFD_IS0_PERIODIC_TIMER_CLK_IN_BIT] ? sb[2] : sc[3];
      periodic_timer_capture_in <= input_source_select_0[`PFD_IS0_PERIODIC_TIMER_CAPTURE_IN_BIT] ? sb[1] : sc[2];
      compact_timer_clk_in <= input_source_select_0[`PFD_IS0_COMPACT_TIMER_CLK_IN_BIT] ? se[2] : sb[4];
    end
  end
endmodule
`default_nettype wire

// ===== bench/pfd_periph_model.sv
// Peripheral signal source beside the pin function block
`default_nettype none
module pfd_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic periph_en,
  output logic [12:0] periph_sig
);
  timeunit 1ns;
  timeprecision 1ps;
  // Disabled lines sit low; enabled lines toggle at random to expose routing slips
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_sig <= 13'h0000;
    end else if (periph_en) begin
      periph_sig <= 13'($urandom);
    end else begin
      periph_sig <= 13'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== bench/pfd_pin_mux_sva.sv
// Checker for the pin function block
`default_nettype none
module pfd_pin_mux_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] gpio_a_data,
  input wire logic [7:0] gpio_a_dir,
  input wire logic [7:0] pad_a_in,
  input wire logic [7:0] pad_a_out,
  input wire logic [7:0] pad_a_oe,
  input wire logic uart_rx_in,
  input wire logic [15:0] drive_c_lvl,
  input wire logic [13:0] drive_d_lvl,
  input wire logic [9:0] drive_e_lvl,
  input wire logic [15:0] drive_f_lvl
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [2:0] up;
  logic [7:0] wd1, wd2, gd1, gr1;
  logic [2:0] rxh;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  // History pipes, so no property needs a sliced past value
  always @(posedge pclk) begin
    wd1 <= pwdata[7:0];
    wd2 <= wd1;
    gd1 <= gpio_a_data;
    gr1 <= gpio_a_dir;
    rxh <= {rxh[1:0], pad_a_in[6]};
  end
  sequence acc_wait;
    psel && penable && !pready;
  endsequence
  sequence wr_at(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  wait_state_a: assert property (acc_wait |=> pready)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero");
  unmapped_err_a: assert property (psel && penable && !pready && paddr > 8'h24 |=> pslverr)
    else $error("unmapped access not refused");
  drive_cd_a: assert property (wr_at(8'h00) |=> ##1
    {drive_d_lvl, drive_c_lvl} == {{3{wd2[7:6]}}, {4{wd2[5:4]}}, {4{wd2[3:2]}}, {4{wd2[1:0]}}})
    else $error("drive c d wrong");
  drive_ef_a: assert property (wr_at(8'h04) |=> ##1
    {drive_f_lvl, drive_e_lvl} == {{4{wd2[7:6]}}, {4{wd2[5:4]}}, wd2[3:2], {4{wd2[1:0]}}})
    else $error("drive e f wrong");
  gpio_only_a: assert property (up > 3'h1 |-> pad_a_out[0] == gd1[0] && pad_a_out[2] == gd1[2] &&
    pad_a_oe[0] == !gr1[0] && pad_a_oe[2] == !gr1[2])
    else $error("plain pin not on port latch");
  rx_route_a: assert property (up > 3'h3 |-> uart_rx_in == rxh[2])
    else $error("receive input not from pin six");
endmodule
bind pfd_pin_mux pfd_pin_mux_chk #(.ADDR_W(ADDR_W)) i_pfd_pin_mux_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .gpio_a_data, .gpio_a_dir, .pad_a_in, .pad_a_out, .pad_a_oe, .uart_rx_in,
  .drive_c_lvl, .drive_d_lvl, .drive_e_lvl, .drive_f_lvl
);
`default_nettype wire

// ===== bench/tb_pfd_pin_mux.sv
// Self-checking bench for the pin function block
`default_nettype none
module tb_pfd_pin_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic periph_en = 1'b0;
  logic chk_on = 1'b0;
  logic err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] gv = 32'h0000_0000;
  logic [36:0] pd = 37'h00_0000_0000;
  logic [31:0] rd, sg;
  logic [12:0] sp;
  logic [36:0] p1, p2, p3, ps;
  logic [7:0] sh [0:7];
  int mismatches = 0;
  int samples_checked = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] pao, paoe, pbo, pboe;
  wire [12:0] pv;
  wire [8:0] rt;
  wire [1:0] xt;
  wire [15:0] dc, df;
  wire [13:0] dd;
  wire [9:0] de;
  pfd_pin_mux i_pfd_pin_mux (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_a_data(gv[31:24]), .gpio_a_dir(gv[23:16]), .gpio_b_data(gv[15:8]), .gpio_b_dir(gv[7:0]),
    .pad_a_in(pd[36:29]), .pad_b_in(pd[28:21]), .pad_c_in(pd[20:13]), .pad_e_in(pd[12:8]), .pad_f_in(pd[7:0]),
    .pad_a_out(pao), .pad_a_oe(paoe), .pad_b_out(pbo), .pad_b_oe(pboe),
    .serial_data_out(pv[0]), .serial_chip_select_out(pv[1]), .serial_chip_select_oe(pv[2]),
    .serial_clock_out(pv[3]), .serial_clock_oe(pv[4]), .serial_data_line_out(pv[5]), .serial_data_line_oe(pv[6]),
    .uart_tx_out(pv[7]), .compact_timer_out(pv[8]), .compact_timer_out_inv(pv[9]), .periodic_timer_out(pv[10]),
    .periodic_timer_out_inv(pv[11]), .comparator_out(pv[12]), .crystal_pin_one(xt[0]), .crystal_pin_two(xt[1]),
    .ext_interrupt_zero(rt[8]), .ext_interrupt_one(rt[7]), .serial_chip_select(rt[6]), .serial_data_in(rt[5]),
    .serial_clock_in(rt[4]), .uart_rx_in(rt[3]), .periodic_timer_clk_in(rt[2]), .periodic_timer_capture_in(rt[1]),
    .compact_timer_clk_in(rt[0]), .drive_c_lvl(dc), .drive_d_lvl(dd), .drive_e_lvl(de), .drive_f_lvl(df)
  );
  pfd_periph_model i_pfd_periph_model (.pclk, .presetn, .periph_en, .periph_sig(pv));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // Pads and port latches change every cycle; snapshots hold what the design sampled
  always @(posedge pclk) begin
    gv <= $urandom;
    pd <= 37'({$urandom, $urandom});
    sg <= gv;
    sp <= pv;
    p1 <= pd;
    p2 <= p1;
    p3 <= p2;
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Returns {oe, out} for one port
  function automatic logic [15:0] epad(input logic [15:0] f, input logic [7:0] m, d, r, po, pe);
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      {v[i+8], v[i]} = (m[i] && f[2*i+:2] == 2'b11) ? {pe[i], po[i]} : {~r[i], d[i]};
    end
    return v;
  endfunction
  // Pad checks pause while a write is in flight, since outputs lag the register
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    chk_on = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= ($urandom << 8) | {24'h00_0000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    ps = p3;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready_wait", n, 2);
    if (w && err === 1'b0 && a < 8'h20) sh[a[4:2]] = (a == 8'h1c) ? (d & 8'h03) : d;
    @(posedge pclk);
    chk_on = 1'b1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    chk("read_data_err", {err, rd}, {ee, e});
  endtask
  always @(negedge pclk) begin
    logic [15:0] ea, eb;
    logic [7:0] a, b, c, f, i0, i1, s1, s2;
    logic [4:0] e;
    if (chk_on) begin
      {a, b, c, e, f} = p3;
      i0 = sh[6];
      i1 = sh[7];
      s1 = sh[0];
      s2 = sh[1];
      ea = epad({sh[3], sh[2]}, 8'hfa, sg[31:24], sg[23:16], {sp[7], 1'b0, sp[3], sp[5], sp[0], 1'b0, sp[1], 1'b0},
        {1'b1, 1'b0, sp[4], sp[6], 1'b1, 1'b0, sp[2], 1'b0});
      eb = epad({sh[5], sh[4]}, 8'hdf, sg[15:8], sg[7:0], {3'b000, sp[9], sp[8], sp[11], sp[10], sp[12]}, 8'h1f);
      chk("port_a_pads", {paoe, pao & ea[15:8]}, {ea[15:8], ea[7:0] & ea[15:8]});
      chk("port_b_pads", {pboe, pbo & eb[15:8]}, {eb[15:8], eb[7:0] & eb[15:8]});
      chk("drive_levels", {dc, dd, de, df}, {{4{s1[3:2]}}, {4{s1[1:0]}}, {3{s1[7:6]}}, {4{s1[5:4]}}, s2[3:2],
        {4{s2[1:0]}}, {4{s2[7:6]}}, {4{s2[5:4]}}});
      chk("crystal", xt, {sh[5][7:6] == 2'b11, sh[5][5:4] == 2'b11});
      chk("routed_in", rt, {i1[0] ? a[6] : a[1], i1[1] ? a[7] : a[3], i0[7] ? f[0] : a[1], i0[6] ? f[2] : a[4],
        i0[5] ? f[3] : a[5], a[6], i0[0] ? b[2] : c[3], i0[3] ? b[1] : c[2], i0[1] ? e[2] : b[4]});
    end
  end
  initial begin
    #200_000;
    chk("watchdog", 1'b0, 1'b1);
    report_and_stop;
  end
  initial begin
    logic [7:0] v, a;
    for (int i = 0; i < 8; i++) sh[i] = 8'h00;
    void'($urandom(32'hf742_c826));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0000_0000, 1'b0);
    for (int c = 0; c < 5; c++) begin
      v = (c < 4) ? {4{2'(c)}} : 8'he4;
      apb(1'b1, 8'h00, v);
      apb(1'b1, 8'h04, v);
      rdc(8'h04, {24'h00_0000, v}, 1'b0);
      repeat (2) @(posedge pclk);
    end
    for (int c = 0; c < 4; c++) begin
      periph_en <= 1'b0;
      for (int r = 2; r < 6; r++) apb(1'b1, 8'(r * 4), {4{2'(c)}});
      periph_en <= 1'b1;
      repeat (16) @(posedge pclk);
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h18, {4{2'(c)}});
      apb(1'b1, 8'h1c, 8'(c));
      repeat (12) @(posedge pclk);
    end
    apb(1'b1, 8'h0c, 8'h03);
    apb(1'b1, 8'h18, 8'h00);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h1c, 8'h02);
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h20, 8'hff);
    chk("status_write", err, 1'b1);
    rdc(8'h28, 32'h0000_0000, 1'b1);
    apb(1'b0, 8'h20, 8'h00);
    chk("port_a_status", {err, rd}, {1'b0, 24'h00_0000, ps[36:29]});
    apb(1'b0, 8'h24, 8'h00);
    chk("port_b_status", {err, rd}, {1'b0, 24'h00_0000, ps[28:21]});
    apb(1'b1, 8'h1c, 8'hff);
    rdc(8'h1c, 32'h0000_0003, 1'b0);
    repeat (200) begin
      a = 8'($urandom_range(7)) << 2;
      apb(1'b1, a, 8'($urandom));
      if ($urandom_range(3) == 0) rdc(a, {24'h00_0000, sh[a[4:2]]}, 1'b0);
    end
    chk_on = 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) sh[i] = 8'h00;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0000_0000, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
